// ===== pll_host_defs.vh
// Offsets, fields, reset values and wait counts of the clock-unit host
`ifndef PLL_HOST_DEFS_VH
`define PLL_HOST_DEFS_VH

// Own registers, reached over the APB slave port
`define REG_CMD 12'h000
`define REG_CFG 12'h004
`define REG_STAT 12'h008
`define REG_TMO 12'h00c
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_SEL_LSB 4
`define CMD_SEL_MSB 5
`define CMD_VAL_LSB 8
`define CMD_VAL_MSB 15
`define CFG_ON_WAKEUP 0
`define CFG_ON_VCO 1
`define CFG_ON_K1_EXT 2
`define TMO_RESET 16'hffff

// Status bits
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ERR_TMO 2
`define ST_ERR_REFUSED 3
`define ST_ERR_BUSY 4
`define ST_OSC_LOCKED 5
`define ST_PLL_LOCKED 6
`define ST_NO_CHANGE 7

// Operation codes
`define OP_DIV 3'h0
`define OP_OSC_START 3'h1
`define OP_PLL_START 3'h2
`define OP_PLL_STOP 3'h3
`define OP_INT_SEL 3'h4
`define OP_WU_FREQ 3'h5

// Device register map
`define DEV_OSC_CTRL 32'h0
`define DEV_SYNTH_ONE 32'h4
`define DEV_WAKEUP 32'h8
`define DEV_LOCK_STAT 32'hc
`define DEV_DIV_BASE 32'h10
// Oscillator control bits
`define OSC_ENABLE 0
`define OSC_SHAPER_BYPASS 1
// Synth control one bits
`define SY_REG_EN 0
`define SY_VCO_EN 1
`define SY_INT_EN 2
`define SY_INT_SEL 3
`define SY_PWR_DOWN 4
`define SY_LKTMO_LSB 8
`define SY_LKTMO_MSB 11
`define LKTMO_MAX 4'hf
// Divider registers: value, acknowledge, ready
`define DIV_ACK 8
`define DIV_READY 16
`define LOCK_FLAG 0

// Reference frequency window after the predivider
`define REF_MIN_KHZ 32'd4000
`define REF_MAX_KHZ 32'd16000

// Waits in 100 ns cycles, sized for the 16-bit counter: 256 us, 50 us, 200 us, 10 us
`define OSC_LOCK_CYC 16'h0a00
`define REG_RAMP_CYC 16'h01f4
`define LOCK_SETTLE_CYC 16'h07d0
`define PDWN_CYC 16'h0064

`endif

// ===== apb_master.v
// Single-transfer APB master toward the clock unit
module apb_master (
    input wire sys_clk,
    input wire sys_rst,
    input wire start,
    input wire wr,
    input wire [31:0] addr,
    input wire [31:0] wdata,
    output reg [31:0] rdata_ff,
    output reg done_ff,
    output reg m_psel_ff,
    output reg m_penable_ff,
    output reg m_pwrite_ff,
    output reg [31:0] m_paddr_ff,
    output reg [31:0] m_pwdata_ff,
    input wire m_pready,
    input wire [31:0] m_prdata
);
    localparam S_IDLE = 2'h0;
    localparam S_SETUP = 2'h1;
    localparam S_ACCESS = 2'h2;

    reg [1:0] state_ff;

    // Request held until pready in the access phase
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
            m_psel_ff <= 1'b0;
            m_penable_ff <= 1'b0;
            m_pwrite_ff <= 1'b0;
            m_paddr_ff <= 32'h0;
            m_pwdata_ff <= 32'h0;
            rdata_ff <= 32'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (start) begin
                        m_psel_ff <= 1'b1;
                        m_pwrite_ff <= wr;
                        m_paddr_ff <= addr;
                        m_pwdata_ff <= wdata;
                        state_ff <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    m_penable_ff <= 1'b1;
                    state_ff <= S_ACCESS;
                end
                S_ACCESS: begin
                    // Unbounded: the slave decides
                    if (m_pready) begin
                        m_psel_ff <= 1'b0;
                        m_penable_ff <= 1'b0;
                        rdata_ff <= m_prdata;
                        done_ff <= 1'b1;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== pll_host_ctrl.v
// Host sequencer that drives the clock unit's registers on software's orders
`include "pll_host_defs.vh"

module pll_host_ctrl #(
    parameter FIN_KHZ = 32'd8000,
    parameter K2_LOCK_DIV = 8'h03
) (
    input wire sys_clk,
    input wire sys_rst,
    // APB slave for the host's own registers
    input wire s_psel,
    input wire s_penable,
    input wire s_pwrite,
    input wire [11:0] s_paddr,
    input wire [31:0] s_pwdata,
    output reg s_pready_ff,
    output reg [31:0] s_prdata_ff,
    output reg s_pslverr_ff,
    // APB master toward the clock unit
    output wire m_psel,
    output wire m_penable,
    output wire m_pwrite,
    output wire [31:0] m_paddr,
    output wire [31:0] m_pwdata,
    input wire m_pready,
    input wire [31:0] m_prdata,
    // Status levels
    output reg busy_ff,
    output reg osc_locked_ff,
    output reg pll_locked_ff
);
    localparam S_IDLE = 4'h0;
    localparam S_RDCUR = 4'h1;
    localparam S_WRNEW = 4'h2;
    localparam S_POLL0 = 4'h3;
    localparam S_WRACK = 4'h4;
    localparam S_POLL1 = 4'h5;
    localparam S_OSCWR = 4'h6;
    localparam S_WAIT = 4'h7;
    localparam S_REGON = 4'h8;
    localparam S_VCOON = 4'h9;
    localparam S_LKRD = 4'ha;
    localparam S_PDWN = 4'hb;
    localparam S_REGOFF = 4'hc;
    localparam S_SELWR = 4'hd;
    localparam S_WUWR = 4'he;
    localparam S_K2PRE = 4'hf;

    reg [3:0] state_ff, nxt_state;
    reg [3:0] ret_ff, nxt_ret;
    reg issued_ff, nxt_issued;
    reg [15:0] cnt_ff, nxt_cnt;
    reg [2:0] op_ff;
    reg [1:0] sel_ff;
    reg [7:0] val_ff;
    reg [2:0] cfg_ff;
    reg [15:0] tmo_lim_ff;
    reg [31:0] synth_ff, nxt_synth;
    reg done_st_ff, err_tmo_ff, err_ref_ff, err_busy_ff, no_change_ff;
    reg nxt_osc_locked, nxt_pll_locked, nxt_done, nxt_err_tmo, nxt_no_change;
    reg bus_start, bus_wr;
    reg [31:0] bus_addr, bus_wdata;
    wire [31:0] bus_rdata;
    wire bus_done;
    wire s_acc;
    wire cmd_wr;
    wire [2:0] cmd_op;
    wire [1:0] cmd_sel;
    wire [7:0] cmd_val;
    reg cmd_ok;

    // Reference frequency after the predivider must sit in the lock window
    function ref_ok;
        input [7:0] p;
        reg [31:0] ref_khz;
        begin
            ref_khz = FIN_KHZ / ({24'h0, p} + 32'h1);
            ref_ok = (ref_khz > `REF_MIN_KHZ) && (ref_khz <= `REF_MAX_KHZ);
        end
    endfunction

    // Divider or mux handshake register address
    function [31:0] div_addr;
        input [1:0] s;
        begin
            div_addr = `DEV_DIV_BASE + {28'h0, s, 2'b00};
        end
    endfunction

    apb_master u_master (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(bus_start),
        .wr(bus_wr),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .rdata_ff(bus_rdata),
        .done_ff(bus_done),
        .m_psel_ff(m_psel),
        .m_penable_ff(m_penable),
        .m_pwrite_ff(m_pwrite),
        .m_paddr_ff(m_paddr),
        .m_pwdata_ff(m_pwdata),
        .m_pready(m_pready),
        .m_prdata(m_prdata)
    );

    // One wait state per slave access keeps the read mux off the bus path
    assign s_acc = s_psel & s_penable & s_pready_ff;
    assign cmd_wr = s_acc & s_pwrite & (s_paddr == `REG_CMD);
    assign cmd_op = s_pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
    assign cmd_sel = s_pwdata[`CMD_SEL_MSB:`CMD_SEL_LSB];
    assign cmd_val = s_pwdata[`CMD_VAL_MSB:`CMD_VAL_LSB];

    // Refuse orders that would break the clock unit's restrictions
    always @* begin
        cmd_ok = 1'b1;
        case (cmd_op)
            `OP_DIV: begin
                if (cmd_sel == 2'h0 && !ref_ok(cmd_val))
                    cmd_ok = 1'b0;
                if (cmd_sel == 2'h2 && cmd_val == 8'h00)
                    cmd_ok = 1'b0;
                if (cmd_sel == 2'h3 && cfg_ff[`CFG_ON_VCO])
                    cmd_ok = 1'b0;
            end
            `OP_PLL_START: cmd_ok = osc_locked_ff;
            `OP_INT_SEL: cmd_ok = !cfg_ff[`CFG_ON_K1_EXT];
            `OP_WU_FREQ: cmd_ok = !cfg_ff[`CFG_ON_WAKEUP];
            `OP_OSC_START, `OP_PLL_STOP: cmd_ok = 1'b1;
            default: cmd_ok = 1'b0;
        endcase
    end

    // Slave side: answer, read mux, register capture
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            s_pready_ff <= 1'b0;
            s_prdata_ff <= 32'h0;
            s_pslverr_ff <= 1'b0;
            cfg_ff <= 3'h0;
            tmo_lim_ff <= `TMO_RESET;
            op_ff <= 3'h0;
            sel_ff <= 2'h0;
            val_ff <= 8'h00;
            err_ref_ff <= 1'b0;
            err_busy_ff <= 1'b0;
        end else begin
            s_pready_ff <= s_psel & s_penable & ~s_pready_ff;
            s_pslverr_ff <= 1'b0;
            if (s_psel & s_penable & ~s_pready_ff) begin
                case (s_paddr)
                    `REG_CMD: s_prdata_ff <= {16'h0000, val_ff, 2'b00, sel_ff, 1'b0, op_ff};
                    `REG_CFG: s_prdata_ff <= {29'h0, cfg_ff};
                    `REG_STAT: s_prdata_ff <= {24'h0, no_change_ff, pll_locked_ff,
                        osc_locked_ff, err_busy_ff, err_ref_ff, err_tmo_ff, done_st_ff,
                        busy_ff};
                    `REG_TMO: s_prdata_ff <= {16'h0000, tmo_lim_ff};
                    default: begin
                        s_prdata_ff <= 32'h0;
                        s_pslverr_ff <= 1'b1;
                    end
                endcase
            end
            if (s_acc & s_pwrite & (s_paddr == `REG_CFG))
                cfg_ff <= s_pwdata[2:0];
            if (s_acc & s_pwrite & (s_paddr == `REG_TMO))
                tmo_lim_ff <= s_pwdata[15:0];
            // Orders while busy are dropped so handshakes never overlap
            if (cmd_wr) begin
                if (busy_ff) begin
                    err_busy_ff <= 1'b1;
                end else begin
                    err_busy_ff <= 1'b0;
                    err_ref_ff <= !cmd_ok;
                    op_ff <= cmd_op;
                    sel_ff <= cmd_sel;
                    val_ff <= cmd_val;
                end
            end
        end
    end

    // Sequencer: each bus step issues once, then waits for its answer
    always @* begin
        nxt_state = state_ff;
        nxt_ret = ret_ff;
        nxt_issued = issued_ff;
        nxt_cnt = cnt_ff;
        nxt_synth = synth_ff;
        nxt_osc_locked = osc_locked_ff;
        nxt_pll_locked = pll_locked_ff;
        nxt_done = done_st_ff;
        nxt_err_tmo = err_tmo_ff;
        nxt_no_change = no_change_ff;
        bus_start = 1'b0;
        bus_wr = 1'b0;
        bus_addr = 32'h0;
        bus_wdata = 32'h0;
        if (state_ff != S_IDLE && state_ff != S_WAIT && !issued_ff) begin
            bus_start = 1'b1;
            nxt_issued = 1'b1;
        end
        if (bus_done)
            nxt_issued = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (cmd_wr && !busy_ff) begin
                    nxt_done = 1'b0;
                    nxt_err_tmo = 1'b0;
                    nxt_no_change = 1'b0;
                    nxt_cnt = 16'h0000;
                    if (!cmd_ok)
                        nxt_done = 1'b1;
                    else begin
                        case (cmd_op)
                            `OP_DIV: nxt_state = S_RDCUR;
                            `OP_OSC_START: nxt_state = S_OSCWR;
                            `OP_PLL_START: nxt_state = S_REGON;
                            `OP_PLL_STOP: nxt_state = S_PDWN;
                            `OP_INT_SEL: nxt_state = S_SELWR;
                            `OP_WU_FREQ: nxt_state = S_WUWR;
                            default: nxt_done = 1'b1;
                        endcase
                    end
                end
            end
            S_RDCUR: begin
                bus_addr = div_addr(sel_ff);
                if (bus_done) begin
                    if (bus_rdata[7:0] == val_ff) begin
                        nxt_no_change = 1'b1;
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end else
                        nxt_state = S_WRNEW;
                end
            end
            S_WRNEW: begin
                // New value with acknowledge cleared in the same write
                bus_wr = 1'b1;
                bus_addr = div_addr(sel_ff);
                bus_wdata = {24'h0, val_ff};
                if (bus_done) begin
                    nxt_cnt = 16'h0000;
                    nxt_state = S_POLL0;
                end
            end
            S_POLL0: begin
                bus_addr = div_addr(sel_ff);
                if (bus_done) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    if (!bus_rdata[`DIV_READY]) begin
                        nxt_state = S_WRACK;
                    end else if (cnt_ff >= tmo_lim_ff) begin
                        nxt_err_tmo = 1'b1;
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_WRACK: begin
                bus_wr = 1'b1;
                bus_addr = div_addr(sel_ff);
                bus_wdata = {23'h0, 1'b1, val_ff};
                if (bus_done) begin
                    nxt_cnt = 16'h0000;
                    nxt_state = S_POLL1;
                end
            end
            S_POLL1: begin
                bus_addr = div_addr(sel_ff);
                if (bus_done) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    if (bus_rdata[`DIV_READY]) begin
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end else if (cnt_ff >= tmo_lim_ff) begin
                        nxt_err_tmo = 1'b1;
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_OSCWR: begin
                bus_wr = 1'b1;
                bus_addr = `DEV_OSC_CTRL;
                bus_wdata = 32'h1 << `OSC_ENABLE;
                if (bus_done) begin
                    nxt_osc_locked = 1'b0;
                    nxt_cnt = `OSC_LOCK_CYC;
                    nxt_ret = S_IDLE;
                    nxt_state = S_WAIT;
                end
            end
            S_WAIT: begin
                // Shared delay; caller sets count and return state
                if (cnt_ff != 16'h0000)
                    nxt_cnt = cnt_ff - 16'h0001;
                else begin
                    nxt_state = ret_ff;
                    if (ret_ff == S_IDLE) begin
                        nxt_done = 1'b1;
                        if (op_ff == `OP_OSC_START)
                            nxt_osc_locked = 1'b1;
                    end
                end
            end
            S_REGON: begin
                bus_wr = 1'b1;
                bus_addr = `DEV_SYNTH_ONE;
                nxt_synth = 32'h1 << `SY_REG_EN;
                nxt_synth[`SY_LKTMO_MSB:`SY_LKTMO_LSB] = `LKTMO_MAX;
                bus_wdata = nxt_synth;
                if (bus_done) begin
                    nxt_pll_locked = 1'b0;
                    nxt_cnt = `REG_RAMP_CYC;
                    nxt_ret = S_K2PRE;
                    nxt_state = S_WAIT;
                end
            end
            S_K2PRE: begin
                // Slow output divider so lock overshoot cannot overclock
                bus_wr = 1'b1;
                bus_addr = div_addr(2'h2);
                bus_wdata = {24'h0, K2_LOCK_DIV};
                if (bus_done)
                    nxt_state = S_VCOON;
            end
            S_VCOON: begin
                bus_wr = 1'b1;
                bus_addr = `DEV_SYNTH_ONE;
                nxt_synth = synth_ff | (32'h1 << `SY_VCO_EN) | (32'h1 << `SY_INT_EN);
                bus_wdata = nxt_synth;
                if (bus_done) begin
                    nxt_cnt = `LOCK_SETTLE_CYC;
                    nxt_ret = S_LKRD;
                    nxt_state = S_WAIT;
                end
            end
            S_LKRD: begin
                bus_addr = `DEV_LOCK_STAT;
                if (bus_done) begin
                    nxt_pll_locked = bus_rdata[`LOCK_FLAG];
                    nxt_done = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_PDWN: begin
                bus_wr = 1'b1;
                bus_addr = `DEV_SYNTH_ONE;
                nxt_synth = synth_ff | (32'h1 << `SY_PWR_DOWN);
                bus_wdata = nxt_synth;
                if (bus_done) begin
                    nxt_pll_locked = 1'b0;
                    nxt_cnt = `PDWN_CYC;
                    nxt_ret = S_REGOFF;
                    nxt_state = S_WAIT;
                end
            end
            S_REGOFF: begin
                bus_wr = 1'b1;
                bus_addr = `DEV_SYNTH_ONE;
                nxt_synth = 32'h1 << `SY_PWR_DOWN;
                bus_wdata = nxt_synth;
                if (bus_done) begin
                    nxt_done = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_SELWR: begin
                bus_wr = 1'b1;
                bus_addr = `DEV_SYNTH_ONE;
                nxt_synth = synth_ff | (32'h1 << `SY_INT_SEL);
                bus_wdata = nxt_synth;
                if (bus_done) begin
                    nxt_done = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_WUWR: begin
                bus_wr = 1'b1;
                bus_addr = `DEV_WAKEUP;
                bus_wdata = {24'h0, val_ff};
                if (bus_done) begin
                    nxt_done = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    // Sequencer registers
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
            ret_ff <= S_IDLE;
            issued_ff <= 1'b0;
            cnt_ff <= 16'h0000;
            synth_ff <= 32'h0;
            osc_locked_ff <= 1'b0;
            pll_locked_ff <= 1'b0;
            done_st_ff <= 1'b0;
            err_tmo_ff <= 1'b0;
            no_change_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ret_ff <= nxt_ret;
            issued_ff <= nxt_issued;
            cnt_ff <= nxt_cnt;
            synth_ff <= (state_ff == S_IDLE) ? synth_ff : nxt_synth;
            osc_locked_ff <= nxt_osc_locked;
            pll_locked_ff <= nxt_pll_locked;
            done_st_ff <= nxt_done;
            err_tmo_ff <= nxt_err_tmo;
            no_change_ff <= nxt_no_change;
            busy_ff <= (nxt_state != S_IDLE);
        end
    end
endmodule

// ===== pll_host_asserts.sv
// Checker for the clock-unit host: bus timing and device programming order
`include "pll_host_defs.vh"
module pll_host_asserts (
    input wire sys_clk,
    input wire sys_rst,
    input wire s_psel,
    input wire s_penable,
    input wire s_pready_ff,
    input wire m_psel,
    input wire m_penable,
    input wire m_pwrite,
    input wire [31:0] m_paddr,
    input wire [31:0] m_pwdata,
    input wire m_pready,
    input wire [31:0] m_prdata,
    input wire osc_locked_ff
);
    logic [15:0] osc_cnt_ff, ramp_cnt_ff;
    logic [31:0] synth_ff;
    logic rdy_ff;
    wire wr_setup = m_psel && !m_penable && m_pwrite;
    wire xfer_end = m_psel && m_penable && m_pready;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence synth_wr;
        wr_setup && m_paddr == `DEV_SYNTH_ONE;
    endsequence
    sequence vco_on_wr;
        synth_wr ##0 m_pwdata[`SY_VCO_EN];
    endsequence
    // Saturating counters, so long idle spans never wrap
    always @(posedge sys_clk) begin
        if (sys_rst || (wr_setup && m_paddr == `DEV_OSC_CTRL)) osc_cnt_ff <= 16'h0;
        else if (osc_cnt_ff != 16'hffff) osc_cnt_ff <= osc_cnt_ff + 16'h1;
        if (sys_rst || (wr_setup && m_paddr == `DEV_SYNTH_ONE && !m_pwdata[`SY_VCO_EN]))
            ramp_cnt_ff <= 16'h0;
        else if (ramp_cnt_ff != 16'hffff) ramp_cnt_ff <= ramp_cnt_ff + 16'h1;
        if (sys_rst) synth_ff <= 32'h0;
        else if (xfer_end && m_pwrite && m_paddr == `DEV_SYNTH_ONE) synth_ff <= m_pwdata;
        if (sys_rst) rdy_ff <= 1'b0;
        else if (xfer_end && !m_pwrite && m_paddr[31:4] == 28'h1) rdy_ff <= m_prdata[`DIV_READY];
    end
    a_slave_answer: assert property (s_psel && $rose(s_penable) |=> s_pready_ff)
        else $error("slave ready late");
    a_ready_pulse: assert property (s_pready_ff |=> !s_pready_ff)
        else $error("slave ready too long");
    a_master_hold: assert property (m_psel && !(m_penable && m_pready) |=> m_psel
        && $stable(m_paddr) && $stable(m_pwdata) && $stable(m_pwrite)) else $error("request moved");
    a_shaper_clear: assert property (wr_setup && m_paddr == `DEV_OSC_CTRL
        |-> !m_pwdata[`OSC_SHAPER_BYPASS]) else $error("shaper bypassed");
    a_osc_wait: assert property ($rose(osc_locked_ff) |-> osc_cnt_ff >= `OSC_LOCK_CYC)
        else $error("oscillator lock early");
    a_vco_after_ramp: assert property (vco_on_wr |-> m_pwdata[`SY_REG_EN]
        && m_pwdata[`SY_INT_EN] && ramp_cnt_ff >= `REG_RAMP_CYC) else $error("vco too early");
    a_pwd_first: assert property (synth_wr ##0 !m_pwdata[`SY_REG_EN]
        |-> synth_ff[`SY_PWR_DOWN]) else $error("regulator off before power down");
    a_pll_osc: assert property (vco_on_wr |-> osc_locked_ff)
        else $error("vco before oscillator lock");
    a_lock_tmo: assert property (synth_wr ##0 m_pwdata[`SY_REG_EN]
        |-> m_pwdata[`SY_LKTMO_MSB:`SY_LKTMO_LSB] == `LKTMO_MAX) else $error("lock timeout");
    a_ack_order: assert property (wr_setup && m_paddr[31:4] == 28'h1 && m_pwdata[`DIV_ACK]
        |-> !rdy_ff) else $error("ack before ready low");
    a_k2_min: assert property (wr_setup && m_paddr == `DEV_DIV_BASE + 32'h8
        |-> m_pwdata[7:0] != 8'h0) else $error("second divider zero");
endmodule
bind pll_host_ctrl pll_host_asserts chk (.*);

// ===== pll_dev_model.sv
// Behavioural clock unit: register file, divider ready handshake, lock flag
`include "pll_host_defs.vh"
module pll_dev_model (
    input wire sys_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:7];
    logic [1:0] wait_ff;
    logic [2:0] settle_ff, sdx_ff;
    wire [2:0] idx = paddr[4:2];
    // Random waits; read data toggles between answers so nothing stale passes
    always @(posedge sys_clk) begin
        pready <= 1'b0;
        prdata <= ~prdata;
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) mem[i] <= 32'h0;
            wait_ff <= 2'h0;
            settle_ff <= 3'h0;
        end else begin
            if (settle_ff != 3'h0) settle_ff <= settle_ff - 3'h1;
            if (settle_ff == 3'h1) mem[sdx_ff][`DIV_READY] <= 1'b1;
            if (psel && !penable) wait_ff <= 2'($urandom_range(3, 0));
            else if (psel && !pready && wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
            else if (psel && !pready) begin
                pready <= 1'b1;
                prdata <= mem[idx];
                if (pwrite && idx < 3'h4) mem[idx] <= pwdata;
                else if (pwrite) mem[idx] <= {15'h0, pwdata[7:0] == mem[idx][7:0]
                    && mem[idx][`DIV_READY], 7'h0, pwdata[8:0]};
                if (pwrite && idx >= 3'h4 && pwdata[`DIV_ACK] && !mem[idx][`DIV_READY]) begin
                    settle_ff <= 3'h4;
                    sdx_ff <= idx;
                end
            end
            mem[3] <= {31'h0, mem[1][`SY_VCO_EN]};
        end
    end
endmodule

// ===== testbench.sv
// Self-checking bench for the clock-unit host with a device model behind it
`include "pll_host_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, sys_rst = 1'b1, s_psel = 1'b0, s_penable = 1'b0, s_pwrite = 1'b0;
    logic [11:0] s_paddr = 12'h0;
    logic [31:0] s_pwdata = 32'h0;
    wire s_pready_ff, s_pslverr_ff, m_psel, m_penable, m_pwrite, m_pready;
    wire busy_ff, osc_locked_ff, pll_locked_ff;
    wire [31:0] s_prdata_ff, m_paddr, m_pwdata, m_prdata;
    int bad_count = 0, tests_run = 0;
    logic [64:0] exp_q [$];
    logic [64:0] e;
    logic [7:0] v;
    // Refusals: config bits, op, selector, value
    logic [15:0] rtab [6] = '{16'h1501, 16'h4400, 16'h2035, 16'h0200, 16'h0020, 16'h0001};
    always #50 sys_clk = ~sys_clk;
    pll_host_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_psel(s_psel),
        .s_penable(s_penable), .s_pwrite(s_pwrite), .s_paddr(s_paddr), .s_pwdata(s_pwdata),
        .s_pready_ff(s_pready_ff), .s_prdata_ff(s_prdata_ff), .s_pslverr_ff(s_pslverr_ff),
        .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr),
        .m_pwdata(m_pwdata), .m_pready(m_pready), .m_prdata(m_prdata), .busy_ff(busy_ff),
        .osc_locked_ff(osc_locked_ff), .pll_locked_ff(pll_locked_ff));
    pll_dev_model dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(m_psel), .penable(m_penable),
        .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata), .pready(m_pready), .prdata(m_prdata));
    // One edge of idle after each transfer keeps drivers from double assignment
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        s_psel <= 1'b1;
        s_pwrite <= w;
        s_paddr <= a;
        s_pwdata <= d;
        @(posedge sys_clk);
        s_penable <= 1'b1;
        do @(posedge sys_clk); while (s_pready_ff !== 1'b1);
        s_psel <= 1'b0;
        s_penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m,
        input logic er);
        exp_q.push_back({er, x, m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [2:0] op, input logic [1:0] sel, input logic [7:0] val);
        apb(1'b1, `REG_CMD, {16'h0, val, 2'h0, sel, 1'b0, op});
        repeat (2) @(posedge sys_clk);
        while (busy_ff !== 1'b0) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        tests_run++;
        if (got !== x) begin
            bad_count++;
            $display("Error %0t: device reg %h exp %h", $time, got, x);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Read monitor: oldest note against the answered read
    always @(posedge sys_clk) begin
        if (s_psel && s_penable && s_pready_ff === 1'b1 && !s_pwrite) begin
            e = exp_q.pop_front();
            tests_run++;
            if ({s_pslverr_ff, s_prdata_ff & e[31:0]} !== {e[64], e[63:32]}) begin
                bad_count++;
                $display("Error %0t: read %h exp %h", $time, s_prdata_ff, e[63:32]);
            end
        end
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        bad_count++;
        final_report();
    end
    initial begin
        void'($urandom(32'h592d));
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`REG_TMO, 32'hffff, 32'hffff, 1'b0);
        rd(`REG_STAT, 32'h0, 32'hff, 1'b0);
        rd(12'h010, 32'h0, 32'hffffffff, 1'b1);
        v = 8'($urandom_range(255, 16));
        apb(1'b1, `REG_TMO, {16'h0, v, 8'h0});
        rd(`REG_TMO, {16'h0, v, 8'h0}, 32'hffff, 1'b0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `REG_CFG, {28'h0, rtab[i][15:12]});
            cmd(rtab[i][10:8], rtab[i][5:4], {4'h0, rtab[i][3:0]});
            rd(`REG_STAT, 32'h0a, 32'hff, 1'b0);
        end
        apb(1'b1, `REG_CMD, {29'h0, `OP_OSC_START});
        cmd(`OP_OSC_START, 2'h0, 8'h0);
        rd(`REG_STAT, 32'h32, 32'hff, 1'b0);
        chk(dev.mem[0], 32'h1);
        cmd(`OP_PLL_START, 2'h0, 8'h0);
        rd(`REG_STAT, 32'h62, 32'hff, 1'b0);
        chk(dev.mem[1], 32'h0f07);
        chk({24'h0, dev.mem[6][7:0]}, 32'h03);
        for (int s = 1; s < 4; s++) begin
            v = 8'($urandom_range(255, 128));
            cmd(`OP_DIV, 2'(s), v);
            chk(dev.mem[4 + s], {15'h0, 1'b1, 7'h0, 1'b1, v});
        end
        cmd(`OP_DIV, 2'h3, v);
        rd(`REG_STAT, 32'h82, 32'h8f, 1'b0);
        cmd(`OP_INT_SEL, 2'h0, 8'h0);
        chk({31'h0, dev.mem[1][`SY_INT_SEL]}, 32'h1);
        cmd(`OP_PLL_STOP, 2'h0, 8'h0);
        chk(dev.mem[1], 32'h10);
        final_report();
    end
endmodule
